// File: verilog/artr_pkg.sv
// Constants and types for the auto-reload capture timer
package artr_pkg;

  // ------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_IDX = 8'hC8;
  localparam logic [7:0] MODE_IDX = 8'hC9;
  localparam logic [7:0] CAPL_IDX = 8'hCA;
  localparam logic [7:0] CAPH_IDX = 8'hCB;
  localparam logic [7:0] CNTL_IDX = 8'hCC;
  localparam logic [7:0] CNTH_IDX = 8'hCD;

  // ------------------------------------------------------------
  // Register select codes
  // ------------------------------------------------------------
  localparam logic [2:0] SEL_CTRL = 3'h0;
  localparam logic [2:0] SEL_MODE = 3'h1;
  localparam logic [2:0] SEL_CAPL = 3'h2;
  localparam logic [2:0] SEL_CAPH = 3'h3;
  localparam logic [2:0] SEL_CNTL = 3'h4;
  localparam logic [2:0] SEL_CNTH = 3'h5;
  localparam logic [2:0] SEL_NONE = 3'h7;

  // ------------------------------------------------------------
  // Mode register fields and reset values
  // ------------------------------------------------------------
  localparam int MODE_HC_LSB = 4;
  localparam int MODE_CR_BIT = 3;
  localparam int MODE_DOWN_COUNT_ENABLE_BIT = 0;
  localparam logic [7:0] MODE_MASK = 8'hF9;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;

  // ------------------------------------------------------------
  // Tick dividers in clock cycles
  // ------------------------------------------------------------
  localparam logic [3:0] DIV_SLOW = 4'hC;
  localparam logic [3:0] DIV_FAST = 4'h4;
  localparam logic [3:0] DIV_BAUD = 4'h2;

  typedef struct packed {
    logic ovf;
    logic ext;
    logic rclk;
    logic transmit_clock_select;
    logic exen;
    logic run;
    logic ct;
    logic cprl;
  } artr_ctrl_t;

endpackage

// File: verilog/artr_fall_det.sv
// Pin synchroniser with falling edge detect
`timescale 1ns/100ps
module artr_fall_det (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_in,
  output logic level,
  output logic fall
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // ------------------------------------------------------------
  // Two stages, then an edge stage; idle level is high
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign level = s2_q;
  assign fall = s3_q & ~s2_q;

endmodule

// File: verilog/artr_timer.sv
// 16-bit auto-reload, capture and baud-rate timer with APB registers
`timescale 1ns/100ps
module artr_timer
  import artr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigger_pin,
  input wire logic count_input_pin,
  input wire logic timer_speed_bit,
  input wire logic timer1_overflow,
  input wire logic serial_mode13,
  input wire logic [3:0] isr_enter,
  output logic overflow_flag,
  output logic external_event_flag,
  output logic timer_irq,
  output logic rx_baud_tick,
  output logic tx_baud_tick,
  output logic [3:0] ext_flag_clear
);

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic logic [2:0] reg_sel(input logic [11:0] a);
    logic [2:0] s;
    s = SEL_NONE;
    if (a[1:0] != 2'h0) begin
      s = SEL_NONE;
    end else if (a[9:2] == CTRL_IDX) begin
      s = SEL_CTRL;
    end else if (a[9:2] == MODE_IDX) begin
      s = SEL_MODE;
    end else if (a[9:2] == CAPL_IDX) begin
      s = SEL_CAPL;
    end else if (a[9:2] == CAPH_IDX) begin
      s = SEL_CAPH;
    end else if (a[9:2] == CNTL_IDX) begin
      s = SEL_CNTL;
    end else if (a[9:2] == CNTH_IDX) begin
      s = SEL_CNTH;
    end
    if (a[11:10] != 2'h0) begin
      s = SEL_NONE;
    end
    return s;
  endfunction

  artr_ctrl_t ctrl_q;
  logic [7:0] mode_q;
  logic [15:0] cnt_q;
  logic [15:0] cap_q;
  logic [3:0] pre_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic rx_q;
  logic tx_q;
  logic [3:0] clr_q;

  logic trig_lvl;
  logic trig_fall;
  logic cnt_fall;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  artr_fall_det u_trig (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(trigger_pin),
    .level(trig_lvl),
    .fall(trig_fall)
  );

  artr_fall_det u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(count_input_pin),
    .level(),
    .fall(cnt_fall)
  );

  // ------------------------------------------------------------
  // Bus strobes
  // ------------------------------------------------------------
  logic setup;
  logic wr_en;
  logic [2:0] sel;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_cap;
  logic wr_cnt;
  logic [7:0] wbyte;

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign sel = reg_sel(paddr);
  assign wbyte = pwdata[7:0];
  assign wr_ctrl = wr_en & (sel == SEL_CTRL);
  assign wr_mode = wr_en & (sel == SEL_MODE);
  assign wr_cap = wr_en & ((sel == SEL_CAPL) | (sel == SEL_CAPH));
  assign wr_cnt = wr_en & ((sel == SEL_CNTL) | (sel == SEL_CNTH));

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  logic baud;
  logic down_count_enable;
  logic down;
  logic trig_ev;
  logic reload_mode;
  logic [3:0] div;
  logic pre_tick;
  logic cnt_tick;
  logic up_ovf;
  logic dn_unf;
  logic wrap;

  assign down_count_enable = mode_q[MODE_DOWN_COUNT_ENABLE_BIT];
  assign baud = ctrl_q.rclk | ctrl_q.transmit_clock_select;
  assign reload_mode = baud | ~ctrl_q.cprl;
  // Direction only matters in plain reload mode
  assign down = down_count_enable & ~baud & ~ctrl_q.cprl & ~trig_lvl;
  // Trigger is dead while baud clocks run
  assign trig_ev = trig_fall & ctrl_q.exen & ~baud;

  // Divider keeps counting across a mode change, so the first tick may run short or long
  assign div = baud ? DIV_BAUD :
               (timer_speed_bit ? DIV_FAST : DIV_SLOW);
  assign pre_tick = (pre_q == 4'(div - 4'h1));
  assign cnt_tick = ctrl_q.run & ((ctrl_q.ct & ~baud) ? cnt_fall :
                    pre_tick);
  assign up_ovf = cnt_tick & ~down & (cnt_q == CNT_MAX);
  assign dn_unf = cnt_tick & down & (cnt_q == cap_q);
  assign wrap = up_ovf | dn_unf;

  // ------------------------------------------------------------
  // Prescaler
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 4'h0;
    end else if (pre_tick || !ctrl_q.run) begin
      pre_q <= 4'h0;
    end else begin
      pre_q <= pre_q + 4'h1;
    end
  end

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= CNT_RST;
    end else if (wr_en && sel == SEL_CNTL) begin
      cnt_q[7:0] <= wbyte;
    end else if (wr_en && sel == SEL_CNTH) begin
      cnt_q[15:8] <= wbyte;
    end else if (trig_ev && ctrl_q.cprl && mode_q[MODE_CR_BIT]) begin
      cnt_q <= CNT_RST;
    end else if (trig_ev && !ctrl_q.cprl && !down_count_enable) begin
      cnt_q <= cap_q;
    end else if (up_ovf) begin
      cnt_q <= reload_mode ? cap_q : CNT_RST;
    end else if (dn_unf) begin
      cnt_q <= CNT_MAX;
    end else if (cnt_tick) begin
      cnt_q <= down ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Capture and reload register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_q <= CNT_RST;
    end else if (wr_en && sel == SEL_CAPL) begin
      cap_q[7:0] <= wbyte;
    end else if (wr_en && sel == SEL_CAPH) begin
      cap_q[15:8] <= wbyte;
    end else if (trig_ev && ctrl_q.cprl) begin
      cap_q <= cnt_q;
    end
  end

  // ------------------------------------------------------------
  // Control register; hardware set wins over software clear
  // ------------------------------------------------------------
  logic ovf_set;
  logic ext_set;

  assign ovf_set = wrap & ~baud;
  assign ext_set = trig_ev | (wrap & down_count_enable & ~ctrl_q.cprl & ~baud);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= artr_ctrl_t'(CTRL_RST);
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= artr_ctrl_t'(wbyte);
      end
      if (ovf_set) begin
        ctrl_q.ovf <= 1'b1;
      end
      if (ext_set) begin
        ctrl_q.ext <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_RST;
    end else if (wr_mode) begin
      mode_q <= wbyte & MODE_MASK;
    end
  end

  // ------------------------------------------------------------
  // Serial time-bases, interrupt and auto-clear outputs
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q <= 1'b0;
      tx_q <= 1'b0;
    end else begin
      rx_q <= serial_mode13 &
              (ctrl_q.rclk ? up_ovf : timer1_overflow);
      tx_q <= serial_mode13 &
              (ctrl_q.transmit_clock_select ? up_ovf : timer1_overflow);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ctrl_q.ovf | ctrl_q.ext;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_q <= 4'h0;
    end else begin
      clr_q <= isr_enter & mode_q[MODE_HC_LSB +: 4];
    end
  end

  // ------------------------------------------------------------
  // APB answer, one wait-free access phase
  // ------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    if (sel == SEL_CTRL) begin
      rd_byte = ctrl_q;
    end else if (sel == SEL_MODE) begin
      rd_byte = mode_q;
    end else if (sel == SEL_CAPL) begin
      rd_byte = cap_q[7:0];
    end else if (sel == SEL_CAPH) begin
      rd_byte = cap_q[15:8];
    end else if (sel == SEL_CNTL) begin
      rd_byte = cnt_q[7:0];
    end else if (sel == SEL_CNTH) begin
      rd_byte = cnt_q[15:8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & (sel == SEL_NONE);
      prdata_q <= (setup && !pwrite) ? {24'h00_0000, rd_byte} :
                  32'h0000_0000;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign overflow_flag = ctrl_q.ovf;
  assign external_event_flag = ctrl_q.ext;
  assign timer_irq = irq_q;
  assign rx_baud_tick = rx_q;
  assign tx_baud_tick = tx_q;
  assign ext_flag_clear = clr_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence apb_setup_s;
    psel && !penable;
  endsequence

  sequence apb_access_s;
    psel && penable && pready;
  endsequence

  apb_answer_a: assert property (apb_setup_s |=> apb_access_s or !psel)
    else $error("access phase not answered in one cycle");

  ovf_set_a: assert property (up_ovf && !baud |=> ctrl_q.ovf)
    else $error("overflow did not set flag");

  down_match_a: assert property (dn_unf |=> ctrl_q.ovf)
    else $error("down match did not set flag");

  baud_noset_a: assert property ($rose(ctrl_q.ovf)
    |-> !$past(baud) || $past(wr_ctrl))
    else $error("flag set while baud clocks run");

  ovf_hold_a: assert property (ctrl_q.ovf && !wr_ctrl
    |=> ctrl_q.ovf)
    else $error("hardware cleared overflow flag");

  ext_edge_a: assert property (trig_ev |=> ctrl_q.ext)
    else $error("trigger edge did not set external flag");

  irq_follow_a: assert property (ctrl_q.ext |=> timer_irq)
    else $error("interrupt not raised");

  rx_base_a: assert property (serial_mode13 && ctrl_q.rclk && up_ovf
    |=> rx_baud_tick)
    else $error("receive time-base wrong");

  tx_base_a: assert property (serial_mode13 && !ctrl_q.transmit_clock_select
    && timer1_overflow |=> tx_baud_tick)
    else $error("transmit time-base wrong");

  baud_reload_a: assert property (baud && up_ovf && !wr_cnt
    |=> cnt_q == $past(cap_q))
    else $error("no reload in baud mode");

  halt_hold_a: assert property (!ctrl_q.run && !wr_cnt && !trig_ev
    |=> $stable(cnt_q))
    else $error("count moved while halted");

  baud_pace_a: assert property (baud && ctrl_q.run && pre_tick
    |=> !pre_tick ##1 pre_tick || !baud || !ctrl_q.run)
    else $error("baud tick not every two clocks");

  capture_a: assert property (trig_ev && ctrl_q.cprl && !wr_cap
    |=> cap_q == $past(cnt_q))
    else $error("capture missed");

  cap_reset_a: assert property (trig_ev && ctrl_q.cprl
    && mode_q[MODE_CR_BIT] && !wr_cnt |=> cnt_q == CNT_RST)
    else $error("capture reset missed");

  auto_clear_a: assert property (isr_enter[0] && mode_q[MODE_HC_LSB]
    |=> ext_flag_clear[0])
    else $error("auto-clear missing");

endmodule

// File: verif/artr_far_model.sv
// Far-side model: trigger pin, count pin and timer 1 overflow
`timescale 1ns/100ps
module artr_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic trig_cmd,
  input wire logic cnt_go,
  input wire logic [3:0] cnt_n,
  output logic trigger_pin,
  output logic count_input_pin,
  output logic timer1_overflow,
  output logic cnt_busy
);
  logic [4:0] t1_q;
  logic [6:0] ph_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t1_q <= 5'h00;
      trigger_pin <= 1'b1;
    end else begin
      t1_q <= (t1_q == 5'h13) ? 5'h00 : t1_q + 5'h01;
      trigger_pin <= trig_cmd;
    end
  end
  assign timer1_overflow = (t1_q == 5'h13);

  // Three clocks low, three high, so the synchroniser sees every edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 7'h00;
    end else if (cnt_go && ph_q == 7'h00) begin
      ph_q <= 7'(cnt_n) * 7'h06;
    end else if (ph_q != 7'h00) begin
      ph_q <= ph_q - 7'h01;
    end
  end
  assign count_input_pin = !(ph_q % 7'h06 >= 7'h03);
  assign cnt_busy = (ph_q != 7'h00);
endmodule

// File: verif/artr_timer_tb_top.sv
// Self-checking bench for the auto-reload capture timer
`timescale 1ns/100ps
module artr_timer_tb_top
  import artr_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, p;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic trigger_pin, count_input_pin, timer_speed_bit, timer1_overflow;
  logic serial_mode13, overflow_flag, external_event_flag, timer_irq;
  logic rx_baud_tick, tx_baud_tick, trig_cmd, cnt_go, cnt_busy;
  logic [3:0] isr_enter, ext_flag_clear, cnt_n;
  logic [7:0] rd, v;
  int mismatches, n_compared, c, e, t;

  artr_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_pin(trigger_pin), .count_input_pin(count_input_pin),
    .timer_speed_bit(timer_speed_bit), .timer1_overflow(timer1_overflow),
    .serial_mode13(serial_mode13), .isr_enter(isr_enter),
    .overflow_flag(overflow_flag), .external_event_flag(external_event_flag),
    .timer_irq(timer_irq), .rx_baud_tick(rx_baud_tick),
    .tx_baud_tick(tx_baud_tick), .ext_flag_clear(ext_flag_clear));
  artr_far_model u_far (.pclk(pclk), .presetn(presetn), .trig_cmd(trig_cmd),
    .cnt_go(cnt_go), .cnt_n(cnt_n), .trigger_pin(trigger_pin),
    .count_input_pin(count_input_pin), .timer1_overflow(timer1_overflow),
    .cnt_busy(cnt_busy));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Baud period in clocks: ticks to overflow, two clocks each
  function automatic logic [15:0] bperiod(input logic [15:0] rl);
    logic [16:0] d;
    d = 17'h10000 - {1'b0, rl};
    return {d[14:0], 1'b0};
  endfunction
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] x,
                     input logic [15:0] g);
    n_compared++;
    if (g !== x) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic tmo();
    mismatches++;
    $display("BAD wait expected done seen timeout");
    close_out();
  endtask
  // Holds the request until pready, then releases after that edge
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // Answer is taken at the edge that samples pready high
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) tmo();
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] idx,
                     input logic [7:0] x);
    apb(1'b0, idx, 8'h00);
    chk(nm, {8'h00, x}, {8'h00, rd});
  endtask
  // Bounded wait: 0 overflow flag, 1 pin pulses done, 2 receive tick
  task automatic wait_on(input int k);
    logic hit;
    c = 0;
    do begin
      @(negedge pclk);
      hit = (k == 0) ? overflow_flag === 1'b1 :
            (k == 1) ? cnt_busy === 1'b0 : rx_baud_tick === 1'b1;
      c++;
      if (c > 400) tmo();
    end while (!hit);
    n_compared++;
    @(posedge pclk);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {timer_speed_bit, serial_mode13, isr_enter, cnt_go, cnt_n} = '0;
    trig_cmd = 1'b1;
    rnd = 32'h694F1AEF;
    mismatches = 0;
    n_compared = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("ctrl", CTRL_IDX, CTRL_RST);
    rdc("mode", MODE_IDX, MODE_RST);
    wr(MODE_IDX, 8'hFF);
    rdc("mode", MODE_IDX, MODE_MASK);
    apb(1'b0, 8'hD0, 8'h00);
    chk("slverr", 16'h0001, {15'h0, err});
    $display("test registers done");
    wr(MODE_IDX, 8'h08);
    for (int i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      wr(CTRL_IDX, 8'h09);
      wr(CNTL_IDX, rnd[7:0]);
      wr(CNTH_IDX, rnd[15:8]);
      trig_cmd <= 1'b0;
      repeat (8) @(posedge pclk);
      chk("ext_flag", 16'h0001, {15'h0, external_event_flag});
      chk("irq", 16'h0001, {15'h0, timer_irq});
      rdc("capl", CAPL_IDX, rnd[7:0]);
      rdc("caph", CAPH_IDX, rnd[15:8]);
      rdc("cnt_rst", CNTL_IDX, 8'h00);
      trig_cmd <= 1'b1;
      wr(CTRL_IDX, 8'h01);
      chk("ext_clr", 16'h0000, {15'h0, external_event_flag});
    end
    trig_cmd <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("ext_off", 16'h0000, {15'h0, external_event_flag});
    trig_cmd <= 1'b1;
    $display("test capture done");
    timer_speed_bit <= 1'b1;
    wr(MODE_IDX, 8'h00);
    wr(CAPH_IDX, 8'h12);
    wr(CAPL_IDX, 8'h00);
    wr(CNTL_IDX, 8'hFC);
    wr(CNTH_IDX, 8'hFF);
    wr(CTRL_IDX, 8'h04);
    wait_on(0);
    repeat (20) @(posedge pclk);
    chk("ovf_hold", 16'h0001, {15'h0, overflow_flag});
    wr(CTRL_IDX, 8'h00);
    chk("ovf_clr", 16'h0000, {15'h0, overflow_flag});
    rdc("reload", CNTH_IDX, 8'h12);
    apb(1'b0, CNTL_IDX, 8'h00);
    v = rd;
    repeat (30) @(posedge pclk);
    rdc("halt", CNTL_IDX, v);
    wr(CNTL_IDX, 8'h5A);
    wr(CTRL_IDX, 8'h08);
    trig_cmd <= 1'b0;
    repeat (8) @(posedge pclk);
    trig_cmd <= 1'b1;
    chk("rl_ext", 16'h0001, {15'h0, external_event_flag});
    rdc("trig_rl", CNTL_IDX, 8'h00);
    wr(CTRL_IDX, 8'h80);
    chk("ovf_sw", 16'h0001, {15'h0, overflow_flag});
    wr(CTRL_IDX, 8'h00);
    $display("test overflow done");
    wr(CNTL_IDX, 8'h00);
    wr(CNTH_IDX, 8'h00);
    wr(CTRL_IDX, 8'h06);
    rnd = lfsr(rnd);
    cnt_n <= rnd[3:0] | 4'h1;
    cnt_go <= 1'b1;
    @(posedge pclk);
    cnt_go <= 1'b0;
    wait_on(1);
    repeat (4) @(posedge pclk);
    wr(CTRL_IDX, 8'h00);
    rdc("pin_cnt", CNTL_IDX, {4'h0, rnd[3:0] | 4'h1});
    $display("test counter done");
    serial_mode13 <= 1'b1;
    wr(CAPL_IDX, 8'hF0);
    wr(CAPH_IDX, 8'hFF);
    // Start near the top, or the first overflow is far too late
    wr(CNTL_IDX, 8'hF0);
    wr(CNTH_IDX, 8'hFF);
    wr(CTRL_IDX, 8'h35);
    wait_on(2);
    wait_on(2);
    chk("period", bperiod(16'hFFF0), c[15:0]);
    chk("ovf_baud", 16'h0000, {15'h0, overflow_flag});
    wr(CTRL_IDX, 8'h14);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    p = timer1_overflow;
    {e, t} = '0;
    repeat (100) begin
      @(negedge pclk);
      if (rx_baud_tick !== p) e++;
      if (tx_baud_tick === 1'b1) t++;
      p = timer1_overflow;
    end
    chk("rx_t1", 16'h0000, e[15:0]);
    chk("tx_own", 16'h0001, {15'h0, t > 0});
    wr(CTRL_IDX, 8'h00);
    serial_mode13 <= 1'b0;
    $display("test baud done");
    for (int j = 0; j < 4; j++) begin
      wr(MODE_IDX, j < 3 ? 8'hF0 : 8'h00);
      rnd = lfsr(rnd);
      isr_enter <= rnd[3:0];
      @(posedge pclk);
      isr_enter <= 4'h0;
      @(negedge pclk);
      chk("auto_clr", {12'h0, j < 3 ? rnd[3:0] : 4'h0},
          {12'h0, ext_flag_clear});
      @(posedge pclk);
    end
    $display("test auto clear done");
    wr(MODE_IDX, 8'h01);
    wr(CAPL_IDX, 8'h00);
    wr(CAPH_IDX, 8'h00);
    wr(CNTL_IDX, 8'h04);
    wr(CNTH_IDX, 8'h00);
    trig_cmd <= 1'b0;
    repeat (6) @(posedge pclk);
    wr(CTRL_IDX, 8'h04);
    wait_on(0);
    wr(CTRL_IDX, 8'h00);
    rdc("down", CNTH_IDX, 8'hFF);
    trig_cmd <= 1'b1;
    $display("test down count done");
    close_out();
  end
endmodule
